// file: rpeq_regs.v
// Receive-port equalizer and interrupt-enable register bank, two ports.
// Assumes an I2C target front end presents byte reads and writes
// as single-cycle strobes on SYS_CLK; event inputs share SYS_CLK.
`timescale 1ns/1ps
`default_nettype none
`include "rpeq_consts.vh"
module rpeq_regs #(
  parameter [19:0] RELOCK_CYCLES = `RPEQ_RELOCK_CYCLES
) (
  input  wire       SYS_CLK,         // System clock, 200 MHz
  input  wire       RST_B,           // Synchronous reset, active low
  input  wire [7:0] REG_ADDR,        // Register byte address
  input  wire       REG_WR,          // Write strobe
  input  wire [7:0] REG_WDATA,       // Write data
  input  wire       REG_RD,          // Read strobe
  output reg  [7:0] REG_RDATA,       // Read data
  output reg        REG_RVALID,      // Read data valid pulse
  input  wire [1:0] LOCK_DET_PIN,    // Lock circuit, per port
  input  wire [1:0] PORT_VALID_PIN,  // Port valid status, per port
  input  wire [1:0] LINK_ENC_EVT,    // Link encoding error
  input  wire [1:0] CTRL_SEQ_EVT,    // Control channel sequence error
  input  wire [1:0] CTRL_CRC_EVT,    // Control channel checksum error
  input  wire [1:0] LINE_LEN_EVT,    // Line length changed
  input  wire [1:0] LINE_CNT_EVT,    // Line count changed
  input  wire [1:0] BUF_OVF_EVT,     // Receive buffer overflow
  input  wire [1:0] CAM_RX_EVT,      // Camera receiver error
  input  wire [1:0] LINK_PAR_EVT,    // Link parity error
  output wire [5:0] EQ_SETTING_P0,   // Equalizer setting, port 0
  output wire [5:0] EQ_SETTING_P1,   // Equalizer setting, port 1
  output wire [1:0] RX_LOCK,         // Reported lock, per port
  output wire [1:0] PORT_IRQ         // Interrupt request, per port
);

  // Global selector and per-port register storage
  reg  [7:0] port_sel;
  reg  [7:0] timing     [0:1];
  reg  [7:0] bypass     [0:1];
  reg  [7:0] limits     [0:1];
  reg  [7:0] rsvd_a     [0:1];
  reg  [7:0] rsvd_b     [0:1];
  reg  [7:0] ien_hi     [0:1];
  reg  [7:0] ien_lo     [0:1];
  integer    p;

  // Pin synchronisers and filtered levels
  reg  [1:0] lock_s1;
  reg  [1:0] lock_s2;
  reg  [1:0] lock_s3;
  reg  [1:0] lock_filt;
  reg  [1:0] valid_s1;
  reg  [1:0] valid_s2;
  reg  [1:0] valid_s3;
  reg  [1:0] valid_filt;
  reg  [1:0] valid_q;
  reg  [1:0] rx_lock_q;

  // Read path
  reg  [7:0] next_rdata;
  wire       rd_port;
  wire [5:0] eq_setting [0:1];
  wire [1:0] rx_lock_int;
  wire [1:0] valid_chg;
  wire [1:0] lock_chg;
  wire [1:0] wr_port;

  assign rd_port = port_sel[`RPEQ_PSEL_RD_PORT];
  assign wr_port = {port_sel[`RPEQ_PSEL_WR_P1], port_sel[`RPEQ_PSEL_WR_P0]};

  // Port selector; only writable bits are kept
  always @(posedge SYS_CLK)
  begin
    if (!RST_B)
      port_sel <= `RPEQ_RST_PORT_SEL;
    else if (REG_WR && (REG_ADDR == `RPEQ_ADDR_PORT_SEL))
      port_sel <= REG_WDATA & `RPEQ_MASK_PORT_SEL;
  end

  // Per-port register writes reach only the selected ports
  always @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      for (p = 0; p < 2; p = p + 1)
      begin
        timing[p] <= `RPEQ_RST_TIMING;
        bypass[p] <= `RPEQ_RST_BYPASS;
        limits[p] <= `RPEQ_RST_LIMITS;
        rsvd_a[p] <= `RPEQ_RST_RSVD;
        rsvd_b[p] <= `RPEQ_RST_RSVD;
        ien_hi[p] <= `RPEQ_RST_IEN;
        ien_lo[p] <= `RPEQ_RST_IEN;
      end
    end
    else if (REG_WR)
    begin
      for (p = 0; p < 2; p = p + 1)
      begin
        if (wr_port[p])
        begin
          case (REG_ADDR)
            `RPEQ_ADDR_TIMING:
              timing[p] <= REG_WDATA & `RPEQ_MASK_TIMING;
            `RPEQ_ADDR_BYPASS:
              bypass[p] <= REG_WDATA;
            `RPEQ_ADDR_LIMITS:
              limits[p] <= REG_WDATA;
            `RPEQ_ADDR_RSVD_A:
              rsvd_a[p] <= REG_WDATA;
            `RPEQ_ADDR_RSVD_B:
              rsvd_b[p] <= REG_WDATA;
            `RPEQ_ADDR_IEN_HI:
              ien_hi[p] <= REG_WDATA & `RPEQ_MASK_IEN_HI;
            `RPEQ_ADDR_IEN_LO:
              ien_lo[p] <= REG_WDATA;
            default:
              ;
          endcase
        end
      end
    end
  end

  // Read data selection from the read-selected port
  always @*
  begin
    next_rdata = 8'h00;
    case (REG_ADDR)
      `RPEQ_ADDR_PORT_SEL:
        next_rdata = port_sel;
      `RPEQ_ADDR_TIMING:
        next_rdata = timing[rd_port];
      `RPEQ_ADDR_STATUS:
        next_rdata = {2'b00, eq_setting[rd_port]};
      `RPEQ_ADDR_BYPASS:
        next_rdata = bypass[rd_port];
      `RPEQ_ADDR_LIMITS:
        next_rdata = limits[rd_port];
      `RPEQ_ADDR_RSVD_A:
        next_rdata = rsvd_a[rd_port];
      `RPEQ_ADDR_RSVD_B:
        next_rdata = rsvd_b[rd_port];
      `RPEQ_ADDR_IEN_HI:
        next_rdata = ien_hi[rd_port];
      `RPEQ_ADDR_IEN_LO:
        next_rdata = ien_lo[rd_port];
      default:
        next_rdata = 8'h00;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      if (REG_RD)
        REG_RDATA <= next_rdata;
    end
  end

  // Three-stage synchronisers with agreement filter on the pins
  always @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      lock_s1    <= 2'b00;
      lock_s2    <= 2'b00;
      lock_s3    <= 2'b00;
      lock_filt  <= 2'b00;
      valid_s1   <= 2'b00;
      valid_s2   <= 2'b00;
      valid_s3   <= 2'b00;
      valid_filt <= 2'b00;
    end
    else
    begin
      lock_s1    <= LOCK_DET_PIN;
      lock_s2    <= lock_s1;
      lock_s3    <= lock_s2;
      lock_filt  <= (~(lock_s2 ^ lock_s3) & lock_s3) | ((lock_s2 ^ lock_s3) & lock_filt);
      valid_s1   <= PORT_VALID_PIN;
      valid_s2   <= valid_s1;
      valid_s3   <= valid_s2;
      valid_filt <= (~(valid_s2 ^ valid_s3) & valid_s3) | ((valid_s2 ^ valid_s3) & valid_filt);
    end
  end

  // History for change detection of valid and reported lock
  always @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      valid_q   <= 2'b00;
      rx_lock_q <= 2'b00;
    end
    else
    begin
      valid_q   <= valid_filt;
      rx_lock_q <= rx_lock_int;
    end
  end

  assign valid_chg = valid_q ^ valid_filt;
  assign lock_chg  = rx_lock_q ^ rx_lock_int;

  // One equalizer engine and one interrupt gate per port
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_port
      wire [9:0] events;
      wire [9:0] enables;

      rpeq_adapt #(
        .WAIT_CYCLES (RELOCK_CYCLES)
      ) u_adapt (
        .clk          (SYS_CLK),
        .rst_b        (RST_B),
        .lock_in      (lock_filt[g]),
        .auto_dis     (bypass[g][`RPEQ_BYP_AUTO_DIS]),
        .manual_upper (bypass[g][`RPEQ_BYP_UPPER_HI:`RPEQ_BYP_UPPER_LO]),
        .manual_lower (bypass[g][`RPEQ_BYP_LOWER_HI:`RPEQ_BYP_LOWER_LO]),
        .lock_mode    (bypass[g][`RPEQ_BYP_LOCK_MODE]),
        .ceiling      (limits[g][`RPEQ_LIM_CEIL_HI:`RPEQ_LIM_CEIL_LO]),
        .start_level  (limits[g][`RPEQ_LIM_FLOOR_HI:`RPEQ_LIM_FLOOR_LO]),
        .floor_en     (timing[g][`RPEQ_TIM_FLOOR_EN]),
        .eq_setting   (eq_setting[g]),
        .lock_out     (rx_lock_int[g])
      );

      // Condition order matches the enable bits high to low
      assign events = {LINK_ENC_EVT[g],
                       CTRL_SEQ_EVT[g],
                       CTRL_CRC_EVT[g],
                       LINE_LEN_EVT[g],
                       LINE_CNT_EVT[g],
                       BUF_OVF_EVT[g],
                       CAM_RX_EVT[g],
                       LINK_PAR_EVT[g],
                       valid_chg[g],
                       lock_chg[g]};
      assign enables = {ien_hi[g][2:0], ien_lo[g][6:0]};

      rpeq_irq #(
        .W (10)
      ) u_irq (
        .clk     (SYS_CLK),
        .rst_b   (RST_B),
        .events  (events),
        .enables (enables),
        .irq     (PORT_IRQ[g])
      );
    end
  endgenerate

  // Outputs taken straight from the engines' flip-flops
  assign EQ_SETTING_P0 = eq_setting[0];
  assign EQ_SETTING_P1 = eq_setting[1];
  assign RX_LOCK       = rx_lock_int;

endmodule
`default_nettype wire

// file: rpeq_consts.vh
// Constants for the receive-port equalizer and interrupt-enable registers.
// Assumes a 200 MHz system clock and an 8-bit register access port.
// Summary of operation
// - Per-port access goes only to selected port
// - Bypass setting is stage-one then stage-two bits
// - Bypass bit one stops adaptation, zero runs
// - Lock mode waits for adaptation before lock
// - Adaptation never exceeds the ceiling field
// - Floor enable starts adaptation from floor value
// - Enable bit gates link encoding error interrupt
// - Enable bit gates control sequence error interrupt
// - Enable bit gates control checksum error interrupt
// - Enable bit gates line length change interrupt
// - Enable bit gates line count change interrupt
// - Enable bit gates buffer overflow interrupt
// - Enable bit gates camera receiver error interrupt
// - Enable bit gates lock change interrupt
// - Floor start resets to one, starts at floor; level still resets to 0, so the first search after reset starts at 0
`ifndef RPEQ_CONSTS_VH
`define RPEQ_CONSTS_VH

// Register byte addresses
`define RPEQ_ADDR_PORT_SEL   8'h4c
`define RPEQ_ADDR_TIMING     8'hd2
`define RPEQ_ADDR_STATUS     8'hd3
`define RPEQ_ADDR_BYPASS     8'hd4
`define RPEQ_ADDR_LIMITS     8'hd5
`define RPEQ_ADDR_RSVD_A     8'hd6
`define RPEQ_ADDR_RSVD_B     8'hd7
`define RPEQ_ADDR_IEN_HI     8'hd8
`define RPEQ_ADDR_IEN_LO     8'hd9

// Port select fields
`define RPEQ_PSEL_WR_P0      0
`define RPEQ_PSEL_WR_P1      1
`define RPEQ_PSEL_RD_PORT    4

// Bypass register fields
`define RPEQ_BYP_AUTO_DIS    0
`define RPEQ_BYP_LOWER_LO    1
`define RPEQ_BYP_LOWER_HI    3
`define RPEQ_BYP_LOCK_MODE   4
`define RPEQ_BYP_UPPER_LO    5
`define RPEQ_BYP_UPPER_HI    7

// Limits register fields
`define RPEQ_LIM_FLOOR_LO    0
`define RPEQ_LIM_FLOOR_HI    3
`define RPEQ_LIM_CEIL_LO     4
`define RPEQ_LIM_CEIL_HI     7

// Timing register field
`define RPEQ_TIM_FLOOR_EN    2

// Reset values
`define RPEQ_RST_PORT_SEL    8'h01
`define RPEQ_RST_TIMING      8'h04
`define RPEQ_RST_BYPASS      8'h60
`define RPEQ_RST_LIMITS      8'hf2
`define RPEQ_RST_RSVD        8'h00
`define RPEQ_RST_IEN         8'h00

// Writable masks
`define RPEQ_MASK_PORT_SEL   8'h13
`define RPEQ_MASK_TIMING     8'h04
`define RPEQ_MASK_IEN_HI     8'h07

// Timing
`define RPEQ_CLK_PERIOD_NS   5
`define RPEQ_RELOCK_TIME_NS  2620000
`define RPEQ_RELOCK_CYCLES   20'd524000

`endif

// file: rpeq_adapt.v
// Adaptive equalizer stepping engine for one receive port.
// Assumes lock_in is already synchronised and filtered on clk.
`timescale 1ns/1ps
`default_nettype none
module rpeq_adapt #(
  parameter [19:0] WAIT_CYCLES = 20'd16
) (
  input  wire       clk,          // System clock
  input  wire       rst_b,        // Synchronous reset, active low
  input  wire       lock_in,      // Lock circuit state
  input  wire       auto_dis,     // Adaptation disabled
  input  wire [2:0] manual_upper, // Manual setting upper bits
  input  wire [2:0] manual_lower, // Manual setting lower bits
  input  wire       lock_mode,    // Lock waits for adaptation
  input  wire [3:0] ceiling,      // Highest adaptive level
  input  wire [3:0] start_level,  // Floor level
  input  wire       floor_en,     // Start from floor
  output reg  [5:0] eq_setting,   // Applied equalizer setting
  output reg        lock_out      // Reported receiver lock
);

  reg  [3:0]  level;
  reg  [19:0] timer;
  reg         done;
  reg         lock_q;
  wire [3:0]  start_raw;
  wire [3:0]  restart;
  wire        expired;
  wire [3:0]  applied;

  // Restart point, clipped so the ceiling always holds
  assign start_raw = floor_en ? start_level : 4'h0;
  assign restart   = (start_raw > ceiling) ? ceiling : start_raw;
  assign expired   = (timer == (WAIT_CYCLES - 20'd1));
  // Level shown to the line, never above a freshly lowered ceiling
  assign applied   = (level > ceiling) ? ceiling : level;

  // Level search and settle qualification
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      level  <= 4'h0;
      timer  <= 20'h00000;
      done   <= 1'b0;
      lock_q <= 1'b0;
    end
    else
    begin
      lock_q <= lock_in;
      if (auto_dis)
      begin
        level <= restart;
        timer <= 20'h00000;
        done  <= 1'b1;
      end
      else if (!lock_in)
      begin
        done <= 1'b0;
        if (lock_q)
        begin
          level <= restart;
          timer <= 20'h00000;
        end
        else if (expired)
        begin
          timer <= 20'h00000;
          level <= (level >= ceiling) ? restart : level + 4'h1;
        end
        else
          timer <= timer + 20'h00001;
      end
      else if (!done)
      begin
        // Settle count starts afresh at the lock edge
        if (!lock_q)
          timer <= 20'h00000;
        else if (expired)
        begin
          done  <= 1'b1;
          timer <= 20'h00000;
        end
        else
          timer <= timer + 20'h00001;
      end
    end
  end

  // Applied setting and qualified lock
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      eq_setting <= 6'h00;
      lock_out   <= 1'b0;
    end
    else
    begin
      eq_setting <= auto_dis ? {manual_upper, manual_lower} : {2'b00, applied};
      lock_out   <= lock_in & (~lock_mode | done);
    end
  end

endmodule
`default_nettype wire

// file: rpeq_irq.v
// Interrupt request gate for one receive port.
// Assumes event inputs are one-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none
module rpeq_irq #(
  parameter W = 10
) (
  input  wire         clk,     // System clock
  input  wire         rst_b,   // Synchronous reset, active low
  input  wire [W-1:0] events,  // Detected conditions
  input  wire [W-1:0] enables, // Per-condition enables
  output reg          irq      // Port interrupt request pulse
);

  // Only enabled conditions raise the request
  always @(posedge clk)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(events & enables);
  end

endmodule
`default_nettype wire

// file: rpeq_regs_props.sv
// Port-level checker for the receive-port register bank.
// Assumes it is bound to rpeq_regs; all signals on SYS_CLK.
`timescale 1ns/1ps
`default_nettype none
module rpeq_regs_props #(
  parameter [19:0] RELOCK_CYCLES = 20'd16
) (
  input wire logic       SYS_CLK,        // Clock
  input wire logic       RST_B,          // Reset, active low
  input wire logic       REG_RD,         // Read strobe
  input wire logic [7:0] REG_RDATA,      // Read data
  input wire logic       REG_RVALID,     // Read valid
  input wire logic [1:0] LOCK_DET_PIN,   // Lock pins
  input wire logic [1:0] PORT_VALID_PIN, // Valid pins
  input wire logic [1:0] LINK_ENC_EVT,   // Conditions
  input wire logic [1:0] CTRL_SEQ_EVT,   // Conditions
  input wire logic [1:0] CTRL_CRC_EVT,   // Conditions
  input wire logic [1:0] LINE_LEN_EVT,   // Conditions
  input wire logic [1:0] LINE_CNT_EVT,   // Conditions
  input wire logic [1:0] BUF_OVF_EVT,    // Conditions
  input wire logic [1:0] CAM_RX_EVT,     // Conditions
  input wire logic [1:0] LINK_PAR_EVT,   // Conditions
  input wire logic [5:0] EQ_SETTING_P0,  // Setting, port 0
  input wire logic [1:0] RX_LOCK,        // Reported lock
  input wire logic [1:0] PORT_IRQ        // Interrupt requests
);
  logic [1:0] ev;
  logic [5:0] now;
  logic [5:0] prev;
  logic [5:0] diff;
  logic [3:0] q0;
  logic [3:0] q1;
  // Any external condition, and pin or lock activity per port
  assign ev   = LINK_ENC_EVT | CTRL_SEQ_EVT | CTRL_CRC_EVT | LINE_LEN_EVT
              | LINE_CNT_EVT | BUF_OVF_EVT | CAM_RX_EVT | LINK_PAR_EVT;
  assign now  = {LOCK_DET_PIN, PORT_VALID_PIN, RX_LOCK};
  assign diff = now ^ prev;
  // Cycles since last pin or lock change, saturating
  always @(posedge SYS_CLK)
  begin
    prev <= now;
    q0   <= (!RST_B || diff[4] || diff[2] || diff[0]) ? 4'h0 : q0 + {3'h0, q0 != 4'hf};
    q1   <= (!RST_B || diff[5] || diff[3] || diff[1]) ? 4'h0 : q1 + {3'h0, q1 != 4'hf};
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  chk_read_answer: assert property (REG_RD |=> REG_RVALID)
    else $error("read not answered next cycle");
  chk_valid_cause: assert property (REG_RVALID |-> $past(REG_RD))
    else $error("read valid without read");
  chk_rdata_hold: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
    else $error("read data moved without read");
  chk_reset_quiet: assert property ($rose(RST_B) |-> PORT_IRQ == 2'h0 && !REG_RVALID
    && RX_LOCK == 2'h0 && EQ_SETTING_P0 == 6'h00)
    else $error("outputs not cleared by reset");
  chk_irq0_cause: assert property (PORT_IRQ[0] && q0 > 4'hc |-> $past(ev[0]))
    else $error("port 0 interrupt without cause");
  chk_irq1_cause: assert property (PORT_IRQ[1] && q1 > 4'hc |-> $past(ev[1]))
    else $error("port 1 interrupt without cause");
  chk_lock0_pin: assert property ($rose(RX_LOCK[0]) |-> $past(LOCK_DET_PIN[0], 3))
    else $error("port 0 lock without lock pin");
  chk_lock1_pin: assert property ($rose(RX_LOCK[1]) |-> $past(LOCK_DET_PIN[1], 3))
    else $error("port 1 lock without lock pin");
  chk_lock_drop: assert property (!LOCK_DET_PIN[0] [*8] |-> !RX_LOCK[0])
    else $error("port 0 lock held after pin loss");
endmodule
bind rpeq_regs rpeq_regs_props #(.RELOCK_CYCLES(RELOCK_CYCLES)) rpeq_regs_props_i (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID), .LOCK_DET_PIN(LOCK_DET_PIN), .PORT_VALID_PIN(PORT_VALID_PIN),
  .LINK_ENC_EVT(LINK_ENC_EVT), .CTRL_SEQ_EVT(CTRL_SEQ_EVT), .CTRL_CRC_EVT(CTRL_CRC_EVT),
  .LINE_LEN_EVT(LINE_LEN_EVT), .LINE_CNT_EVT(LINE_CNT_EVT), .BUF_OVF_EVT(BUF_OVF_EVT),
  .CAM_RX_EVT(CAM_RX_EVT), .LINK_PAR_EVT(LINK_PAR_EVT), .EQ_SETTING_P0(EQ_SETTING_P0),
  .RX_LOCK(RX_LOCK), .PORT_IRQ(PORT_IRQ));
`default_nettype wire

// file: rpeq_host.sv
// Host model issuing single-byte register reads and writes.
// Assumes strobes are taken on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module rpeq_host (
  input  wire logic       clk,    // System clock
  input  wire logic [7:0] rdata,  // Read data
  input  wire logic       rvalid, // Read valid pulse
  output var  logic [7:0] addr,   // Register address
  output var  logic       wr,     // Write strobe
  output var  logic [7:0] wdata,  // Write data
  output var  logic       rd      // Read strobe
);
  // Idle bus at time zero
  initial
  begin
    addr  = 8'h00;
    wr    = 1'b0;
    wdata = 8'h00;
    rd    = 1'b0;
  end
  // One write; data line shows the inverse once released
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask
  // One read; waits a bounded time for the valid pulse
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      if (rvalid === 1'b1)
        d = rdata;
    end
  endtask
  // Port selector write: write-port mask and read-port bit
  task automatic select(input logic [1:0] wp, input logic rp);
    write_reg(8'h4c, {3'h0, rp, 2'h0, wp});
  endtask
endmodule
`default_nettype wire

// file: rpeq_tb.sv
// Self-checking bench for the receive-port register bank.
// Assumes a shortened relock count of 16 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  logic       SYS_CLK;
  logic       RST_B;
  logic [7:0] addr, wdata, rdata;
  logic       wr, rd, rvalid;
  logic [1:0] lock_pin, valid_pin, rx_lock, irq;
  logic [1:0] evt [8];
  logic [5:0] eq0, eq1, mn, mx;
  logic [7:0] ra [9] = '{8'h4c, 8'hd2, 8'hd4, 8'hd5, 8'hd6, 8'hd7, 8'hd8, 8'hd9, 8'h00};
  logic [7:0] rv [9] = '{8'h01, 8'h04, 8'h60, 8'hf2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int         bad_count, checked, n;
  rpeq_regs #(.RELOCK_CYCLES(20'd16)) rpeq_regs_i (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
    .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .LOCK_DET_PIN(lock_pin),
    .PORT_VALID_PIN(valid_pin), .LINK_ENC_EVT(evt[0]), .CTRL_SEQ_EVT(evt[1]),
    .CTRL_CRC_EVT(evt[2]), .LINE_LEN_EVT(evt[3]), .LINE_CNT_EVT(evt[4]),
    .BUF_OVF_EVT(evt[5]), .CAM_RX_EVT(evt[6]), .LINK_PAR_EVT(evt[7]),
    .EQ_SETTING_P0(eq0), .EQ_SETTING_P1(eq1), .RX_LOCK(rx_lock), .PORT_IRQ(irq));
  rpeq_host rpeq_host_i (.clk(SYS_CLK), .rdata(rdata), .rvalid(rvalid), .addr(addr),
    .wr(wr), .wdata(wdata), .rd(rd));
  // Verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Read one register and compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rpeq_host_i.read_reg(a, v);
    `CHK("register", e, v)
  endtask
  // Count interrupt cycles on one port
  task automatic watch(input int p, input int cyc, output int cnt);
    cnt = 0;
    repeat (cyc)
    begin
      @(negedge SYS_CLK);
      cnt += (irq[p] === 1'b1);
    end
  endtask
  // Pulse one condition for one cycle, then count interrupts
  task automatic fire(input int i, input int p, output int cnt);
    @(posedge SYS_CLK);
    evt[i][p] <= 1'b1;
    @(posedge SYS_CLK);
    evt[i][p] <= 1'b0;
    watch(p, 4, cnt);
  endtask
  // Lowest and highest port 0 setting over a span
  task automatic scan(input int cyc);
    mn = 6'h3f;
    mx = 6'h00;
    repeat (cyc)
    begin
      @(negedge SYS_CLK);
      if (eq0 < mn) mn = eq0;
      if (eq0 > mx) mx = eq0;
    end
  endtask
  // Clock
  initial
  begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  // Watchdog
  initial
  begin
    #100000;
    bad_count++;
    $display("BAD watchdog exp finish got hang");
    conclude();
  end
  // Test sequence
  initial
  begin
    RST_B = 1'b0;
    lock_pin = 2'h0;
    valid_pin = 2'h0;
    foreach (evt[k]) evt[k] = 2'h0;
    repeat (4) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    for (int k = 0; k < 9; k++)
      rchk(ra[k], rv[k]);
    $display("test reset values done");
    rpeq_host_i.write_reg(8'hd8, 8'hff);
    rpeq_host_i.write_reg(8'hd9, 8'hff);
    rpeq_host_i.write_reg(8'h10, 8'hff);
    rchk(8'hd8, 8'h07);
    rchk(8'hd9, 8'hff);
    rchk(8'h10, 8'h00);
    rpeq_host_i.write_reg(8'hd8, 8'h00);
    rpeq_host_i.write_reg(8'hd9, 8'h00);
    $display("test access kinds done");
    rpeq_host_i.write_reg(8'hd4, 8'ha7);
    rpeq_host_i.write_reg(8'hd3, 8'hff);
    rpeq_host_i.select(2'h2, 1'b1);
    rpeq_host_i.write_reg(8'hd4, 8'h5d);
    repeat (4) @(posedge SYS_CLK);
    `CHK("setting p0", 6'h2b, eq0)
    `CHK("setting p1", 6'h16, eq1)
    rchk(8'hd4, 8'h5d);
    rpeq_host_i.select(2'h1, 1'b0);
    rchk(8'hd4, 8'ha7);
    rchk(8'hd3, 8'h2b);
    $display("test bypass done");
    for (int i = 0; i < 8; i++)
    begin
      fire(i, 0, n);
      `CHK("masked irq", 0, n)
      rpeq_host_i.write_reg(i < 3 ? 8'hd8 : 8'hd9, 8'h01 << (i < 3 ? 2 - i : 9 - i));
      fire(i, 0, n);
      `CHK("enabled irq", 1, n)
      fire(i, 1, n);
      `CHK("other port irq", 0, n)
      rpeq_host_i.write_reg(i < 3 ? 8'hd8 : 8'hd9, 8'h00);
    end
    $display("test interrupt enables done");
    rpeq_host_i.write_reg(8'hd4, 8'h00);
    rpeq_host_i.write_reg(8'hd9, 8'h03);
    lock_pin[0] <= 1'b1;
    watch(0, 12, n);
    `CHK("lock irq", 1, n)
    `CHK("lock mode 0", 1'b1, rx_lock[0])
    @(posedge SYS_CLK);
    valid_pin[0] <= 1'b1;
    watch(0, 12, n);
    `CHK("valid irq", 1, n)
    rpeq_host_i.write_reg(8'hd9, 8'h00);
    valid_pin[0] <= 1'b0;
    lock_pin[0] <= 1'b0;
    watch(0, 12, n);
    `CHK("masked pins", 0, n)
    rpeq_host_i.select(2'h2, 1'b1);
    rpeq_host_i.write_reg(8'hd4, 8'h10);
    lock_pin[1] <= 1'b1;
    repeat (10) @(posedge SYS_CLK);
    `CHK("lock mode 1 early", 1'b0, rx_lock[1])
    for (int k = 0; k < 60 && rx_lock[1] !== 1'b1; k++)
      @(negedge SYS_CLK);
    `CHK("lock mode 1 late", 1'b1, rx_lock[1])
    $display("test lock done");
    rpeq_host_i.select(2'h1, 1'b0);
    rpeq_host_i.write_reg(8'hd5, 8'h31);
    repeat (40) @(posedge SYS_CLK);
    scan(160);
    `CHK("ceiling", 6'h03, mx)
    `CHK("floor start", 6'h01, mn)
    rpeq_host_i.write_reg(8'hd2, 8'h00);
    repeat (40) @(posedge SYS_CLK);
    scan(160);
    `CHK("zero start", 6'h00, mn)
    `CHK("ceiling again", 6'h03, mx)
    $display("test adaptation limits done");
    conclude();
  end
endmodule
`default_nettype wire
